// ---- verilog/gpio_led_defs.vh ----
`ifndef GPIO_LED_DEFS_VH
`define GPIO_LED_DEFS_VH

// Register offsets
`define OFS_PIN_CFG 12'h088
`define OFS_IRQ_EN 12'h0C0
`define OFS_IRQ_STS 12'h0C4

// Field positions in the configuration register
`define LED_LSB 28
`define POL_LSB 24
`define EEF_LSB 20
`define DRV_LSB 16
`define DIR_LSB 8
`define GPO_LSB 3
`define DATA_LSB 0

// Reset values
`define RST_3 3'h0
`define RST_2 2'h0

// Pin function codes
`define EEF_EEPROM 3'h0
`define EEF_GPO34 3'h1
`define EEF_OUTPUT_ONLY_PIN3_RXDV 3'h3
`define EEF_TXEN_OUTPUT_ONLY_PIN4 3'h5
`define EEF_TXEN_RXDV 3'h6
`define EEF_CLOCKS 3'h7

// Persistence time before a level counts
`define PERSIST_NS 40
`define CLK_NS 50
`define PERSIST_CYC ((`PERSIST_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- verilog/pin_sync_filter.v ----
`timescale 1ns/10ps
`include "gpio_led_defs.vh"

module pin_sync_filter #(
    parameter N = 4
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire ce,
    // Pins
    input wire [N-1:0] pin_async,
    // Synchronised and persistence-qualified levels
    output wire [N-1:0] sync_q,
    output wire [N-1:0] filt_q
);

    localparam integer PERSIST_INT = `PERSIST_CYC;
    localparam [1:0] PERSIST = PERSIST_INT[1:0];

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1)
        begin : g_pin
            reg s1_reg;
            reg s2_reg;
            reg filt_reg;
            reg [1:0] cnt_reg;
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    filt_reg <= 1'b0;
                    cnt_reg <= 2'h0;
                end
                else if (ce)
                begin
                    s1_reg <= pin_async[i];
                    s2_reg <= s1_reg;
                    if (s2_reg != filt_reg)
                    begin
                        if (cnt_reg + 2'h1 >= PERSIST)
                        begin
                            filt_reg <= s2_reg;
                            cnt_reg <= 2'h0;
                        end
                        else
                            cnt_reg <= cnt_reg + 2'h1;
                    end
                    else
                        cnt_reg <= 2'h0;
                end
            end
            assign sync_q[i] = s2_reg;
            assign filt_q[i] = filt_reg;
        end
    endgenerate

endmodule // pin_sync_filter

// ---- verilog/eeprom_pin_mux.v ----
`timescale 1ns/10ps
`include "gpio_led_defs.vh"

module eeprom_pin_mux (
    // Function select
    input wire [2:0] code,
    // EEPROM controller side
    input wire ee_data_out,
    input wire ee_data_oe,
    input wire ee_clk,
    // Alternate sources
    input wire [1:0] gpo,
    input wire tx_en,
    input wire tx_clk,
    input wire rx_dv,
    input wire rx_clk,
    // Pin values
    output reg data_out,
    output reg data_oe,
    output reg clk_out
);

    always @*
    begin
        data_out = ee_data_out;
        data_oe = ee_data_oe;
        clk_out = ee_clk;
        case (code)
            `EEF_GPO34:
            begin
                data_out = gpo[0];
                data_oe = 1'b1;
                clk_out = gpo[1];
            end
            `EEF_OUTPUT_ONLY_PIN3_RXDV:
            begin
                data_out = gpo[0];
                data_oe = 1'b1;
                clk_out = rx_dv;
            end
            `EEF_TXEN_OUTPUT_ONLY_PIN4:
            begin
                data_out = tx_en;
                data_oe = 1'b1;
                clk_out = gpo[1];
            end
            `EEF_TXEN_RXDV:
            begin
                data_out = tx_en;
                data_oe = 1'b1;
                clk_out = rx_dv;
            end
            `EEF_CLOCKS:
            begin
                data_out = tx_clk;
                data_oe = 1'b1;
                clk_out = rx_clk;
            end
            default:
            begin
                data_out = ee_data_out;
                data_oe = ee_data_oe;
                clk_out = ee_clk;
            end
        endcase
    end

endmodule // eeprom_pin_mux

// ---- verilog/gpio_led_pin_config.v ----
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "gpio_led_defs.vh"

module gpio_led_pin_config (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // General-purpose pins
    input wire [2:0] gpio_in,
    output reg [2:0] gpio_out,
    output reg [2:0] gpio_oe,
    // LED status sources
    input wire [2:0] led_status,
    // EEPROM controller side
    input wire ee_data_out,
    input wire ee_data_oe,
    input wire ee_clk,
    output reg ee_data_in,
    // Monitor sources
    input wire tx_en,
    input wire tx_clk,
    input wire rx_dv,
    input wire rx_clk,
    // EEPROM pins
    input wire eeprom_data_pin_in,
    output reg eeprom_data_pin_out,
    output reg eeprom_data_pin_oe,
    output reg eeprom_clock_pin,
    // Host interrupt
    output reg host_irq
);

    // Configuration fields
    reg [2:0] led_pin_select_reg;
    reg [2:0] pin_irq_level_select_reg;
    reg [2:0] eeprom_pin_function_reg;
    reg [2:0] pin_drive_type_reg;
    reg [2:0] pin_direction_reg;
    reg [1:0] output_only_data_reg;
    reg [2:0] pin_data_reg;

    // Interrupt enable and status
    reg [2:0] pin_irq_enable_reg;
    reg [2:0] interrupt_status_reg;

    // Synchronised pins
    wire [3:0] pin_sync;
    wire [3:0] pin_filt;

    // Pin mux results
    wire mux_data_out;
    wire mux_data_oe;
    wire mux_clk_out;

    // Decoded bus access
    wire setup_acc;
    wire wr_fire;
    wire hit_cfg;
    wire hit_en;
    wire hit_sts;
    wire hit_any;

    // Level condition and next values
    wire [2:0] level_hit;
    reg [2:0] sts_next;
    wire [2:0] pin_val;
    wire [2:0] drive_on;
    wire [2:0] out_next;
    wire [2:0] oe_next;
    reg [31:0] rd_next;
    genvar g;

    pin_sync_filter #(
        .N(4)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pin_async({eeprom_data_pin_in, gpio_in}),
        .sync_q(pin_sync),
        .filt_q(pin_filt)
    );

    eeprom_pin_mux u_mux (
        .code(eeprom_pin_function_reg),
        .ee_data_out(ee_data_out),
        .ee_data_oe(ee_data_oe),
        .ee_clk(ee_clk),
        .gpo(output_only_data_reg),
        .tx_en(tx_en),
        .tx_clk(tx_clk),
        .rx_dv(rx_dv),
        .rx_clk(rx_clk),
        .data_out(mux_data_out),
        .data_oe(mux_data_oe),
        .clk_out(mux_clk_out)
    );

    // Address decode
    assign hit_cfg = (paddr == `OFS_PIN_CFG);
    assign hit_en = (paddr == `OFS_IRQ_EN);
    assign hit_sts = (paddr == `OFS_IRQ_STS);
    assign hit_any = hit_cfg | hit_en | hit_sts;
    assign setup_acc = psel & penable & ~pready;
    assign wr_fire = psel & penable & pready & pwrite;

    // Read data
    always @*
    begin
        rd_next = 32'h0;
        if (hit_cfg)
        begin
            rd_next[`LED_LSB +: 3] = led_pin_select_reg;
            rd_next[`POL_LSB +: 3] = pin_irq_level_select_reg;
            rd_next[`EEF_LSB +: 3] = eeprom_pin_function_reg;
            rd_next[`DRV_LSB +: 3] = pin_drive_type_reg;
            rd_next[`DIR_LSB +: 3] = pin_direction_reg;
            rd_next[`GPO_LSB +: 2] = output_only_data_reg;
            rd_next[`DATA_LSB +: 3] = pin_sync[2:0];
        end
        else if (hit_en)
            rd_next[2:0] = pin_irq_enable_reg;
        else if (hit_sts)
            rd_next[2:0] = interrupt_status_reg;
    end

    // Per-pin level condition and drive
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_pin
            wire is_gpio_in;
            wire lvl_match;
            wire led_on;
            wire push_pull;

            // Only plain input pins raise a condition
            assign is_gpio_in = ~pin_direction_reg[g]
                & ~led_pin_select_reg[g];
            assign lvl_match = pin_irq_level_select_reg[g]
                ? pin_filt[g]
                : ~pin_filt[g];
            assign level_hit[g] = lvl_match & is_gpio_in;

            // LED source or written data
            assign led_on = led_pin_select_reg[g];
            assign pin_val[g] = led_on
                ? led_status[g]
                : pin_data_reg[g];
            assign drive_on[g] = led_on | pin_direction_reg[g];

            // Open-drain only ever pulls low
            assign push_pull = pin_drive_type_reg[g];
            assign out_next[g] = push_pull & pin_val[g];
            assign oe_next[g] = drive_on[g]
                & (push_pull | ~pin_val[g]);
        end
    endgenerate

    // Status update, a new condition wins over a clear
    always @*
    begin
        sts_next = interrupt_status_reg;
        if (wr_fire && hit_sts)
            sts_next = sts_next & ~pwdata[2:0];
        sts_next = sts_next | level_hit;
    end

    // APB handshake
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else if (ce)
        begin
            if (setup_acc)
            begin
                pready <= 1'b1;
                pslverr <= ~hit_any;
                prdata <= pwrite ? 32'h0 : rd_next;
            end
            else
            begin
                pready <= 1'b0;
                pslverr <= 1'b0;
                prdata <= 32'h0;
            end
        end
    end

    // Configuration register
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            led_pin_select_reg <= `RST_3;
            pin_irq_level_select_reg <= `RST_3;
            eeprom_pin_function_reg <= `RST_3;
            pin_drive_type_reg <= `RST_3;
            pin_direction_reg <= `RST_3;
            output_only_data_reg <= `RST_2;
            pin_data_reg <= `RST_3;
        end
        else if (ce && wr_fire && hit_cfg)
        begin
            // Reserved positions are never stored
            led_pin_select_reg <= pwdata[`LED_LSB +: 3];
            pin_irq_level_select_reg <= pwdata[`POL_LSB +: 3];
            eeprom_pin_function_reg <= pwdata[`EEF_LSB +: 3];
            pin_drive_type_reg <= pwdata[`DRV_LSB +: 3];
            pin_direction_reg <= pwdata[`DIR_LSB +: 3];
            output_only_data_reg <= pwdata[`GPO_LSB +: 2];
            pin_data_reg <= pwdata[`DATA_LSB +: 3];
        end
    end

    // Interrupt enable and status
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_irq_enable_reg <= `RST_3;
            interrupt_status_reg <= `RST_3;
            host_irq <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_fire && hit_en)
                pin_irq_enable_reg <= pwdata[2:0];
            interrupt_status_reg <= sts_next;
            host_irq <= |(interrupt_status_reg & pin_irq_enable_reg);
        end
    end

    // Registered pin outputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gpio_out <= 3'h0;
            gpio_oe <= 3'h0;
            eeprom_data_pin_out <= 1'b0;
            eeprom_data_pin_oe <= 1'b0;
            eeprom_clock_pin <= 1'b0;
            ee_data_in <= 1'b0;
        end
        else if (ce)
        begin
            gpio_out <= out_next;
            gpio_oe <= oe_next;
            eeprom_data_pin_out <= mux_data_out;
            eeprom_data_pin_oe <= mux_data_oe;
            eeprom_clock_pin <= mux_clk_out;
            ee_data_in <= pin_sync[3];
        end
    end

endmodule // gpio_led_pin_config

// ---- verif/gpio_led_props.sv ----
`timescale 1ns/10ps
module gpio_led_props (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Pins
    input wire [2:0] gpio_in,
    input wire [2:0] gpio_out,
    input wire [2:0] gpio_oe,
    input wire [2:0] led_status,
    input wire tx_clk,
    input wire rx_clk,
    input wire eeprom_data_pin_out,
    input wire eeprom_data_pin_oe,
    input wire eeprom_clock_pin,
    input wire host_irq
);
    reg [31:0] cfg;
    reg [2:0] en;
    wire wr = psel && penable && pready && pwrite;
    wire map = paddr == 12'h088 || paddr == 12'h0C0 || paddr == 12'h0C4;
    wire lvl = !cfg[8] && !cfg[28] && en[0] && gpio_in[0] == cfg[24];
    // Shadow of written settings
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg <= 32'h0;
            en <= 3'h0;
        end
        else if (wr && paddr == 12'h088)
            cfg <= pwdata;
        else if (wr && paddr == 12'h0C0)
            en <= pwdata[2:0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc; psel && penable && !pready && ce; endsequence
    sequence s_lvl; lvl [*6]; endsequence
    property p_rdy; s_acc |=> pready ##1 !pready; endproperty
    property p_err; pready |-> pslverr == !map; endproperty
    property p_rsv; pready && !pwrite && paddr == 12'h088
        |-> (prdata & 32'h8888F8E0) == 32'h0; endproperty
    property p_led; $past(cfg[28] && cfg[16])
        |-> gpio_oe[0] && gpio_out[0] == $past(led_status[0]); endproperty
    property p_pp; $past(cfg[8] && cfg[16] && !cfg[28])
        |-> gpio_oe[0] && gpio_out[0] == $past(cfg[0]); endproperty
    property p_od; $past(cfg[9] && !cfg[17] && !cfg[29])
        |-> !gpio_out[1] && gpio_oe[1] == !$past(cfg[1]); endproperty
    property p_mux; $past(cfg[22:20] == 3'h7)
        |-> eeprom_data_pin_out == $past(tx_clk)
        && eeprom_clock_pin == $past(rx_clk); endproperty
    property p_gpo; $past(cfg[22:20] == 3'h1)
        |-> eeprom_data_pin_oe && eeprom_data_pin_out == $past(cfg[3])
        && eeprom_clock_pin == $past(cfg[4]); endproperty
    property p_irq; s_lvl |-> host_irq; endproperty
    property p_noirq; en == 3'h0 && $past(en == 3'h0) |-> !host_irq;
    endproperty
    a_rdy: assert property (p_rdy) else $error("bad ready");
    a_err: assert property (p_err) else $error("bad slverr");
    a_rsv: assert property (p_rsv) else $error("bad rsv");
    a_led: assert property (p_led) else $error("bad led");
    a_pp: assert property (p_pp) else $error("bad out");
    a_od: assert property (p_od) else $error("bad od");
    a_mux: assert property (p_mux) else $error("bad mux");
    a_gpo: assert property (p_gpo) else $error("bad gpo");
    a_irq: assert property (p_irq) else $error("no irq");
    a_noirq: assert property (p_noirq) else $error("irq");
endmodule // gpio_led_props

bind gpio_led_pin_config gpio_led_props u_props (.pclk, .presetn, .ce,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .gpio_in, .gpio_out, .gpio_oe, .led_status, .tx_clk, .rx_clk,
    .eeprom_data_pin_out, .eeprom_data_pin_oe, .eeprom_clock_pin,
    .host_irq);

// ---- verif/pin_world.sv ----
`timescale 1ns/10ps
module pin_world (
    // Design drive
    input wire [2:0] gpio_out,
    input wire [2:0] gpio_oe,
    input wire eeprom_data_pin_out,
    input wire eeprom_data_pin_oe,
    // Outside drive
    input wire [2:0] ext_en,
    input wire [2:0] ext_val,
    // Resolved levels
    output wire [2:0] gpio_in,
    output wire eeprom_data_pin_in
);
    // Pull-up wherever nobody drives
    assign gpio_in = (gpio_oe & gpio_out)
        | (~gpio_oe & (~ext_en | ext_val));
    assign eeprom_data_pin_in = eeprom_data_pin_oe ? eeprom_data_pin_out
        : 1'b1;
endmodule // pin_world

// ---- verif/tb.sv ----
`timescale 1ns/10ps
`define CHK(a,b) begin compares=compares+1; if((a)!==(b)) begin \
 err_count=err_count+1; $display("MISMATCH %0t %h", $time, a); end end
module tb;
    reg pclk=0, presetn=0, psel=0, penable=0, pwrite=0, ee_data_out=0;
    reg ee_data_oe=0, ee_clk=1, tx_en=0, tx_clk=1, rx_dv=1, rx_clk=0, e;
    reg [11:0] paddr=12'h000;
    reg [31:0] pwdata=32'h0, q;
    reg [2:0] led_status=3'h0, ext_en=3'h0, ext_val=3'h0, c, x;
    wire [31:0] prdata;
    wire [2:0] gpio_in, gpio_out, gpio_oe;
    wire pready, pslverr, ee_data_in, eeprom_data_pin_in;
    wire eeprom_data_pin_out, eeprom_data_pin_oe, eeprom_clock_pin, host_irq;
    wire [2:0] ee_pins = {eeprom_data_pin_oe, eeprom_data_pin_out,
        eeprom_clock_pin};
    localparam [17:0] CODES = 18'h3EAC8;
    localparam [17:0] PINS = 18'h359F1;
    integer err_count=0, compares=0, i;
    always #25 pclk = ~pclk;
    gpio_led_pin_config u_dut (.pclk, .presetn, .ce(1'b1), .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .gpio_in, .gpio_out, .gpio_oe, .led_status, .ee_data_out,
        .ee_data_oe, .ee_clk, .ee_data_in, .tx_en, .tx_clk, .rx_dv,
        .rx_clk, .eeprom_data_pin_in, .eeprom_data_pin_out,
        .eeprom_data_pin_oe, .eeprom_clock_pin, .host_irq);
    pin_world u_pins (.gpio_out, .gpio_oe, .eeprom_data_pin_out,
        .eeprom_data_pin_oe, .ext_en, .ext_val, .gpio_in,
        .eeprom_data_pin_in);
    task test_done;
    begin
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge pclk);
    endtask
    task xfer(input w, input [11:0] a, input [31:0] d);
        integer n;
    begin
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n = n + 1;
            @(posedge pclk);
        end
        if (n >= 20)
        begin
            err_count = err_count + 1;
            $display("MISMATCH %0t no pready", $time);
            test_done;
        end
        else
        begin
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    end
    endtask
    task t_regs;
    begin
        xfer(1'b0, 12'h088, 32'h0);
        `CHK(q, 32'h7)
        xfer(1'b1, 12'h088, 32'h8888F8E0);
        xfer(1'b0, 12'h088, 32'h0);
        `CHK(q, 32'h7)
        xfer(1'b0, 12'h100, 32'h0);
        `CHK({e, q}, 33'h100000000)
    end
    endtask
    task t_out;
    begin
        xfer(1'b1, 12'h088, 32'h00070705);
        cyc(3);
        `CHK({gpio_oe, gpio_out}, 6'h3D)
        xfer(1'b0, 12'h088, 32'h0);
        `CHK(q, 32'h00070705)
        ext_en <= 3'h1;
        xfer(1'b1, 12'h088, 32'h00000705);
        cyc(3);
        `CHK({gpio_oe, gpio_out}, 6'h10)
        xfer(1'b0, 12'h088, 32'h0);
        `CHK(q, 32'h00000704)
    end
    endtask
    task t_led;
    begin
        ext_en <= 3'h0;
        led_status <= 3'h6;
        xfer(1'b1, 12'h088, 32'h70070000);
        cyc(3);
        `CHK({gpio_oe, gpio_out}, 6'h3E)
        xfer(1'b1, 12'h088, 32'h70000000);
        cyc(3);
        `CHK({gpio_oe, gpio_out}, 6'h08)
    end
    endtask
    // Legal codes only, EEPROM idle
    task t_mux;
    begin
        for (i = 0; i < 6; i = i + 1)
        begin
            c = CODES[i*3 +: 3];
            x = PINS[i*3 +: 3];
            xfer(1'b1, 12'h088, {9'h0, c, 12'h0, 8'h08});
            cyc(5);
            `CHK(ee_pins, x)
            `CHK(ee_data_in, !x[2] | x[1])
        end
        tx_en <= 1'b1;
        rx_dv <= 1'b0;
        tx_clk <= 1'b0;
        rx_clk <= 1'b1;
        xfer(1'b1, 12'h088, 32'h00600000);
        cyc(3);
        `CHK(ee_pins, 3'h6)
        xfer(1'b1, 12'h088, 32'h00700000);
        cyc(3);
        `CHK(ee_pins, 3'h5)
    end
    endtask
    // Levels held for many cycles
    task t_irq;
    begin
        ext_en <= 3'h1;
        ext_val <= 3'h1;
        // Drop a level latched while a pin left LED use
        xfer(1'b1, 12'h0C4, 32'h7);
        xfer(1'b0, 12'h0C4, 32'h0);
        `CHK(q, 32'h0)
        xfer(1'b1, 12'h0C0, 32'h1);
        xfer(1'b1, 12'h088, 32'h0);
        cyc(8);
        `CHK(host_irq, 1'b0)
        xfer(1'b1, 12'h088, 32'h01000000);
        cyc(8);
        `CHK(host_irq, 1'b1)
        xfer(1'b0, 12'h0C4, 32'h0);
        `CHK(q, 32'h1)
        ext_val <= 3'h0;
        cyc(8);
        xfer(1'b1, 12'h0C4, 32'h1);
        cyc(3);
        `CHK(host_irq, 1'b0)
        xfer(1'b1, 12'h088, 32'h0);
        cyc(8);
        `CHK(host_irq, 1'b1)
        xfer(1'b1, 12'h0C0, 32'h0);
        cyc(3);
        `CHK(host_irq, 1'b0)
        xfer(1'b0, 12'h0C4, 32'h0);
        `CHK(q, 32'h1)
    end
    endtask
    initial
    begin
        cyc(16);
        presetn <= 1'b1;
        t_regs;
        t_out;
        t_led;
        t_mux;
        t_irq;
        test_done;
    end
endmodule // tb
